// >>> src/dpc_map.svh
// constants for the displacement pulse counter
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH
// ----------------------------------------------------------------
// count width, step, reset values and levels
// ----------------------------------------------------------------
`define DPC_CNT_W 32
`define DPC_PH_IDLE 2'h3
`define DPC_LVL_ACTIVE 1'h0
`define DPC_STEP 32'h00000001
`endif

// >>> src/dpc_pkg.sv
// types for the displacement pulse counter
package dpc_pkg;
  // ----------------------------------------------------------------
  // modes and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DPC_MODE_SINGLE = 2'h1,
    DPC_MODE_QUAD = 2'h2
  } dpc_mode_t;
  typedef enum logic [1:0] {
    DPC_IN_VOLTAGE = 2'h1,
    DPC_IN_PULSE = 2'h2
  } dpc_in_type_t;
  typedef struct packed {
    logic a_pos;
    logic a_neg;
    logic b_pos;
    logic b_neg;
  } dpc_diff_t;
  typedef struct packed {
    logic up;
    logic down;
  } dpc_step_t;
endpackage

// >>> src/dpc_decode.sv
// phase receiver and edge decoder of the displacement pulse counter
`include "dpc_map.svh"
module dpc_decode (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // sensor pairs and mode
  input wire dpc_pkg::dpc_diff_t diff_in,
  input wire dpc_pkg::dpc_mode_t mode_in,
  // count steps
  output dpc_pkg::dpc_step_t step_out
);
  logic [1:0] ph_d;
  logic [1:0] ph_q;
  logic [1:0] rx;
  dpc_pkg::dpc_step_t step_d;
  dpc_pkg::dpc_step_t step_q;

  // ----------------------------------------------------------------
  // receiver and edge decode
  // ----------------------------------------------------------------
  // pair to single-ended: positive above negative reads high
  assign rx = {diff_in.b_pos & ~diff_in.b_neg, diff_in.a_pos & ~diff_in.a_neg};

  // previous levels; idle is high, so reset does not fake an edge
  always_comb begin
    ph_d = rx;
    step_d = '0;
    if (mode_in == dpc_pkg::DPC_MODE_SINGLE) begin
      // active is low: count on the high-to-low change of phase A
      step_d.up = ph_q[0] & (rx[0] == `DPC_LVL_ACTIVE);
    end else if (mode_in == dpc_pkg::DPC_MODE_QUAD) begin
      // both phases changing at once is illegal for quadrature; dropped
      if ((rx[0] != ph_q[0]) && (rx[1] == ph_q[1])) begin
        step_d.up = rx[0] ^ rx[1];
        step_d.down = ~(rx[0] ^ rx[1]);
      end else if ((rx[1] != ph_q[1]) && (rx[0] == ph_q[0])) begin
        step_d.up = ~(rx[0] ^ rx[1]);
        step_d.down = rx[0] ^ rx[1];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ph_q <= `DPC_PH_IDLE;
      step_q <= '0;
    end else begin
      ph_q <= ph_d;
      step_q <= step_d;
    end
  end

  assign step_out = step_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_a_fall;
    ph_q[0] && !rx[0];
  endsequence

  a_single_a_fall: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (mode_in == dpc_pkg::DPC_MODE_SINGLE) and s_a_fall |=> step_out.up)
    else $error("single mode missed a phase A fall");
  a_single_no_down: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $past(mode_in) == dpc_pkg::DPC_MODE_SINGLE |-> !step_out.down)
    else $error("single mode counted down");
  a_quad_every_edge: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (mode_in == dpc_pkg::DPC_MODE_QUAD) && ((rx ^ ph_q) == 2'h1 || (rx ^ ph_q) == 2'h2)
    |=> (step_out.up ^ step_out.down))
    else $error("quadrature edge not counted");
  a_quad_dir_a: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (mode_in == dpc_pkg::DPC_MODE_QUAD) && (rx ^ ph_q) == 2'h1 && (rx[0] != rx[1])
    |=> step_out.up)
    else $error("phase A edge direction wrong");
  a_quad_dir_b: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (mode_in == dpc_pkg::DPC_MODE_QUAD) && (rx ^ ph_q) == 2'h2 && (rx[0] != rx[1])
    |=> step_out.down)
    else $error("phase B edge direction wrong");
  a_idle_no_step: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    (rx == ph_q) |=> !step_out.up && !step_out.down)
    else $error("count step without an edge");
endmodule

// >>> src/dpc_counter.sv
// top of the displacement pulse counter: supplies, count and zeroing
`include "dpc_map.svh"
module dpc_counter #(
  parameter int CNT_W = `DPC_CNT_W
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // sensor link
  input wire dpc_pkg::dpc_diff_t diff_in,
  // settings and control
  input wire dpc_pkg::dpc_mode_t mode_in,
  input wire dpc_pkg::dpc_in_type_t in_type_in,
  input wire logic zero_displacement_in,
  // supplies and count
  output logic voltage_sensor_supply_out,
  output logic pulse_sensor_supply_out,
  output logic [CNT_W-1:0] count_out
);
  dpc_pkg::dpc_step_t step;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cnt_q;
  logic vsup_d;
  logic vsup_q;
  logic psup_d;
  logic psup_q;
  logic zero_prev_d;
  logic zero_prev_q;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // rising edge of a level against its registered copy; used by logic and checks
  function automatic logic rise_f(input logic now, input logic prev);
    return now & ~prev;
  endfunction

  // ----------------------------------------------------------------
  // edge decoder
  // ----------------------------------------------------------------
  dpc_decode u_decode (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .diff_in(diff_in),
    .mode_in(mode_in),
    .step_out(step)
  );

  // ----------------------------------------------------------------
  // count and supplies
  // ----------------------------------------------------------------
  // zeroing wins over a step in the same cycle; acts on the rising edge of the request
  always_comb begin
    cnt_d = cnt_q;
    zero_prev_d = zero_displacement_in;
    if (rise_f(zero_displacement_in, zero_prev_q)) begin
      cnt_d = '0;
    end else if (step.up) begin
      cnt_d = cnt_q + CNT_W'(`DPC_STEP);
    end else if (step.down) begin
      cnt_d = cnt_q - CNT_W'(`DPC_STEP);
    end
    // only one supply ever on; unknown code keeps both off
    vsup_d = (in_type_in == dpc_pkg::DPC_IN_VOLTAGE);
    psup_d = (in_type_in == dpc_pkg::DPC_IN_PULSE);
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q <= '0;
      vsup_q <= 1'h0;
      psup_q <= 1'h0;
      zero_prev_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      vsup_q <= vsup_d;
      psup_q <= psup_d;
      zero_prev_q <= zero_prev_d;
    end
  end

  assign count_out = cnt_q;
  assign voltage_sensor_supply_out = vsup_q;
  assign pulse_sensor_supply_out = psup_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_supply_exclusive: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !(voltage_sensor_supply_out && pulse_sensor_supply_out))
    else $error("both sensor supplies on");
  a_supply_follows: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    in_type_in == dpc_pkg::DPC_IN_PULSE |=> pulse_sensor_supply_out)
    else $error("pulse supply not on");
  a_zero_clears: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    zero_displacement_in && !zero_prev_q |=> count_out == '0)
    else $error("zeroing did not clear count");
  a_count_up: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    step.up && !(zero_displacement_in && !zero_prev_q) |=> count_out == $past(cnt_q) + 1'b1)
    else $error("count did not step up");

  // zeroing request seen this cycle
  sequence s_zero_edge;
    rise_f(zero_displacement_in, zero_prev_q);
  endsequence

  // no step and no zeroing this cycle
  sequence s_quiet;
    !step.up && !step.down && !rise_f(zero_displacement_in, zero_prev_q);
  endsequence

  // a decoder step is one direction only
  a_step_one_way: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !(step.up && step.down))
    else $error("step up and down together");

  // down steps move the count by exactly one, wrapping below zero
  a_count_down: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    step.down && !step.up && !rise_f(zero_displacement_in, zero_prev_q)
    |=> count_out == $past(cnt_q) - 1'b1)
    else $error("count did not step down");

  // without a step or zeroing the count stands
  a_count_holds: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_quiet |=> count_out == $past(cnt_q))
    else $error("count moved without a step");

  // zeroing wins over a step in the same cycle
  a_zero_wins: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    s_zero_edge and (step.up || step.down) |=> count_out == '0)
    else $error("step beat zeroing");

  // a held zeroing level clears once, then counting resumes
  a_zero_held_counts: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    zero_displacement_in && zero_prev_q && step.up && !step.down
    |=> count_out == $past(cnt_q) + 1'b1)
    else $error("held zeroing blocked counting");

  // voltage input type turns on only the voltage supply
  a_supply_voltage: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    in_type_in == dpc_pkg::DPC_IN_VOLTAGE
    |=> voltage_sensor_supply_out && !pulse_sensor_supply_out)
    else $error("voltage supply not on alone");

  // pulse input type keeps the voltage supply off
  a_supply_pulse_only: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    in_type_in == dpc_pkg::DPC_IN_PULSE |=> !voltage_sensor_supply_out)
    else $error("voltage supply on for pulse input");

  // an unknown input type leaves the sensor unpowered rather than guessing
  a_supply_none: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    in_type_in != dpc_pkg::DPC_IN_VOLTAGE && in_type_in != dpc_pkg::DPC_IN_PULSE
    |=> !voltage_sensor_supply_out && !pulse_sensor_supply_out)
    else $error("supply on for unknown input type");

  // mode codes outside the two modes never produce a step
  a_mode_off_idle: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    $past(mode_in) != dpc_pkg::DPC_MODE_SINGLE && $past(mode_in) != dpc_pkg::DPC_MODE_QUAD
    |-> !step.up && !step.down)
    else $error("step in an unknown mode");
endmodule

// >>> test/dpc_sensor_model.sv
// behavioural incremental sensor with complementary square-wave pairs
module dpc_sensor_model (
  // phase levels from the bench
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  // differential pairs toward the counter
  output dpc_pkg::dpc_diff_t diff_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // each phase leaves as a true and inverted line, never both equal
  assign diff_out = {phase_a_in, ~phase_a_in, phase_b_in, ~phase_b_in};
endmodule

// >>> test/displacement_pulse_counter_tb.sv
// self-checking bench for the displacement pulse counter
module displacement_pulse_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic pa = 1'b1;
  logic pb = 1'b1;
  logic zero = 1'b0;
  dpc_pkg::dpc_mode_t mode = dpc_pkg::DPC_MODE_SINGLE;
  dpc_pkg::dpc_in_type_t in_type = dpc_pkg::DPC_IN_VOLTAGE;
  dpc_pkg::dpc_diff_t diff;
  logic v_sup;
  logic p_sup;
  logic [31:0] count;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  // ----------------------------------------------------------------
  // clock, sensor and device
  // ----------------------------------------------------------------
  always #2 sys_clk = ~sys_clk;
  dpc_sensor_model i_sensor (.phase_a_in(pa), .phase_b_in(pb), .diff_out(diff));
  dpc_counter i_dut (.sys_clk_in(sys_clk), .reset_in(reset), .diff_in(diff), .mode_in(mode),
    .in_type_in(in_type), .zero_displacement_in(zero), .voltage_sensor_supply_out(v_sup),
    .pulse_sensor_supply_out(p_sup), .count_out(count));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // change phases just after an edge, then wait out the two-edge latency
  task automatic drive(input logic a, input logic b);
    @(posedge sys_clk);
    #1;
    pa = a;
    pb = b;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_supply();
    in_type = dpc_pkg::DPC_IN_PULSE;
    drive(pa, pb);
    chk("pulse supply", 32'({p_sup, v_sup}), 32'h00000002);
    in_type = dpc_pkg::DPC_IN_VOLTAGE;
    drive(pa, pb);
    chk("voltage supply", 32'({p_sup, v_sup}), 32'h00000001);
  endtask
  // rises of a and every move of b must be ignored here
  task automatic t_single();
    mode = dpc_pkg::DPC_MODE_SINGLE;
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b0);
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    chk("single count", count, 32'h00000002);
  endtask
  task automatic t_zero();
    zero = 1'b1;
    drive(pa, pb);
    chk("zeroed count", count, 32'h00000000);
    zero = 1'b0;
  endtask
  // forward cycle, reverse cycle, then one step below zero to wrap
  task automatic t_quad();
    mode = dpc_pkg::DPC_MODE_QUAD;
    drive(1'b0, 1'b1);
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
    chk("forward count", count, 32'h00000004);
    drive(1'b1, 1'b0);
    drive(1'b0, 1'b0);
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    chk("reverse count", count, 32'h00000000);
    drive(1'b1, 1'b0);
    chk("wrapped count", count, 32'hFFFFFFFF);
  endtask
  // unknown mode and input codes: no counting, no supply
  task automatic t_codes();
    mode = dpc_pkg::dpc_mode_t'(2'h0);
    in_type = dpc_pkg::dpc_in_type_t'(2'h3);
    drive(1'b0, 1'b1);
    chk("idle mode count", count, 32'hFFFFFFFF);
    chk("no supply", 32'({p_sup, v_sup}), 32'h00000000);
  endtask
  // zeroing edge meets a pending down step in the same cycle
  task automatic t_zero_race();
    mode = dpc_pkg::DPC_MODE_QUAD;
    in_type = dpc_pkg::DPC_IN_VOLTAGE;
    @(posedge sys_clk);
    #1;
    pa = 1'b1;
    @(posedge sys_clk);
    #1;
    zero = 1'b1;
    @(posedge sys_clk);
    #1;
    chk("zero beats step", count, 32'h00000000);
    zero = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("count after race", count, 32'h00000000);
  endtask
  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    chk("reset count", count, 32'h00000000);
    reset = 1'b0;
    t_supply();
    t_single();
    t_zero();
    t_quad();
    t_codes();
    t_zero_race();
    wrap_up();
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      wrap_up();
    end
  end
endmodule
